// file: design/adc_common_ctl.sv
// How it works
// - bit 15 of the module control word switches the converter on; resets off.
// - idle-stop set halts the module while the device idles.
// - format bit 7 picks fractional when one, integer when zero.
// - resolution code 11/10/01/00 gives 12/10/8/6 bits; resets to 12.
// - early enable routes per-input interrupts from early flags, else done.
// - early lead code N puts the early flag N+1 core clocks ahead.
// - core clock period is twice the divider code, minimum two.
// - shared sample time is code plus two core clocks.
// - ready interrupt enable raises the common interrupt on reference ready.
// - error interrupt enable raises the common interrupt on reference error.
// - reference ready status is read-only and follows the band gap.
// - reference error sets when the band gap drops while enabled.
// - external request enable lets the trigger generator request conversions.
// - unimplemented bits ignore writes and read zero.
// - flag bits and the channel and pulse trigger bits are hardware driven; level trigger and other fields plain R/W.
// - suspend blocks the channel, level and pulse triggers to all cores; external request enable is not gated by it.
// - suspended ready sets when suspended and idle; may raise the interrupt.
// - single channel trigger fires once for the chosen channel, self-clears.
// - level trigger fires continuously; pulse trigger fires once, self-clears.
`timescale 1ns/10ps
`default_nettype none
module adc_common_ctl
   import adc_ctl_pkg::*;
#(
   parameter int N_INPUTS = 24
)
(
   // clock and reset
   input  wire logic                          I_MCLK,
   input  wire logic                          I_RESETN,
   // apb slave
   input  wire logic                          I_PSEL,
   input  wire logic                          I_PENABLE,
   input  wire logic                          I_PWRITE,
   input  wire logic [11:0]                   I_PADDR,
   input  wire logic [31:0]                   I_PWDATA,
   input  wire logic [3:0]                    I_PSTRB,
   output var  logic [31:0]                   O_PRDATA,
   output var  logic                          O_PREADY,
   output var  logic                          O_PSLVERR,
   // device and analog status
   input  wire logic                          I_IDLE,
   input  wire logic                          I_BANDGAP_READY,
   input  wire logic                          I_CONV_BUSY,
   input  wire logic [N_INPUTS-1:0]           I_EARLY_STATUS,
   input  wire logic [N_INPUTS-1:0]           I_CONV_DONE,
   // core configuration
   output var  logic                          O_MODULE_ON,
   output var  logic                          O_FRACTIONAL,
   output var  logic [adc_ctl_pkg::RES_W-1:0] O_SHARED_RES,
   output var  logic [3:0]                    O_SHARED_RES_BITS,
   output var  logic [3:0]                    O_EARLY_LEAD_CYCLES,
   output var  logic [7:0]                    O_CORE_CLK_DIV,
   output var  logic [10:0]                   O_SAMPLE_CYCLES,
   output var  logic [2:0]                    O_REFERENCE_SELECT,
   output var  logic                          O_EXT_REQUEST_EN,
   output var  logic                          O_MANUAL_SAMPLING,
   // triggers and interrupts
   output var  logic                          O_CHANNEL_TRIGGER,
   output var  logic [5:0]                    O_TRIGGER_CHANNEL,
   output var  logic                          O_LEVEL_TRIGGER,
   output var  logic                          O_PULSE_TRIGGER,
   output var  logic [N_INPUTS-1:0]           O_INPUT_IRQ,
   output var  logic                          O_COMMON_IRQ
);
   import adc_ctl_pkg::*;

   state_t              st_q;
   state_t              st_d;
   logic [N_INPUTS-1:0] input_irq_q;
   logic [15:0]         cur;
   logic [15:0]         wd;
   logic                hit;
   logic                wr;
   logic                setup;
   logic                trig_ok;

   // ************************************************************
   // register read view and decode
   // ************************************************************
   always_comb
   begin
      hit = 1'b1;
      cur = 16'h0000;
      if (I_PADDR == OFS_MODULE_CONTROL)
      begin
         cur[BIT_MODULE_ENABLE] = st_q.module_enable;
         cur[BIT_IDLE_STOP]     = st_q.idle_stop;
      end
      else if (I_PADDR == OFS_FORMAT_RESOLUTION)
      begin
         cur[BIT_FRACTIONAL] = st_q.fractional_format;
         cur[POS_RES_LO +: RES_W] = st_q.shared_resolution;
      end
      else if (I_PADDR == OFS_SHARED_TIMING)
      begin
         cur[BIT_RDY_IRQ_EN]   = st_q.ref_ready_irq_en;
         cur[BIT_ERR_IRQ_EN]   = st_q.ref_error_irq_en;
         cur[BIT_EARLY_IRQ_EN] = st_q.early_irq_en;
         cur[BIT_EXT_REQ_EN]   = st_q.ext_request_en;
         cur[POS_LEAD_LO +: LEAD_W] = st_q.shared_early_lead;
         cur[POS_DIV_LO +: DIV_W]   = st_q.shared_clock_divider;
      end
      else if (I_PADDR == OFS_REF_STATUS_SAMPLE)
      begin
         cur[BIT_REF_READY] = st_q.bg_sync;
         cur[BIT_REF_ERROR] = st_q.ref_error_flag;
         cur[POS_SAMPLE_LO +: SAMPLE_W] = st_q.shared_sample_time;
      end
      else if (I_PADDR == OFS_TRIGGER_SUSPEND)
      begin
         cur[POS_REFERENCE_SELECT_LO +: REFERENCE_SELECT_W] = st_q.reference_select;
         cur[BIT_SUSPEND]     = st_q.suspend;
         cur[BIT_SUSP_IRQ_EN] = st_q.suspend_irq_en;
         cur[BIT_SUSP_READY]  = st_q.suspended_ready_flag;
         cur[BIT_MANUAL_SAMP] = st_q.shared_manual_sampling;
         cur[BIT_CHAN_TRIG]   = st_q.single_channel_trigger;
         cur[BIT_LEVEL_TRIG]  = st_q.level_soft_trigger;
         cur[BIT_PULSE_TRIG]  = st_q.pulse_soft_trigger;
         cur[POS_CHAN_LO +: CHAN_W] = st_q.trigger_channel_number;
      end
      else
      begin
         hit = 1'b0;
      end
   end

   assign setup     = I_PSEL && !I_PENABLE;
   assign wr        = I_PSEL && I_PENABLE && I_PWRITE && hit;
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = I_PSEL && I_PENABLE && !hit;
   assign O_PRDATA  = st_q.prdata;

   // byte lanes merge over current contents
   assign wd[BYTE_W-1:0]        = I_PSTRB[0] ? I_PWDATA[BYTE_W-1:0]
                                             : cur[BYTE_W-1:0];
   assign wd[2*BYTE_W-1:BYTE_W] = I_PSTRB[1] ? I_PWDATA[2*BYTE_W-1:BYTE_W]
                                             : cur[2*BYTE_W-1:BYTE_W];

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      st_d = st_q;
      st_d.prdata = setup ? {16'h0000, cur} : st_q.prdata;
      // self-clearing one-shot triggers
      st_d.single_channel_trigger = 1'b0;
      st_d.pulse_soft_trigger     = 1'b0;
      if (wr && I_PADDR == OFS_MODULE_CONTROL)
      begin
         st_d.module_enable = wd[BIT_MODULE_ENABLE];
         st_d.idle_stop     = wd[BIT_IDLE_STOP];
      end
      else if (wr && I_PADDR == OFS_FORMAT_RESOLUTION)
      begin
         st_d.fractional_format = wd[BIT_FRACTIONAL];
         st_d.shared_resolution = wd[POS_RES_LO +: RES_W];
      end
      else if (wr && I_PADDR == OFS_SHARED_TIMING)
      begin
         st_d.ref_ready_irq_en     = wd[BIT_RDY_IRQ_EN];
         st_d.ref_error_irq_en     = wd[BIT_ERR_IRQ_EN];
         st_d.early_irq_en         = wd[BIT_EARLY_IRQ_EN];
         st_d.ext_request_en       = wd[BIT_EXT_REQ_EN];
         st_d.shared_early_lead    = wd[POS_LEAD_LO +: LEAD_W];
         st_d.shared_clock_divider = wd[POS_DIV_LO +: DIV_W];
      end
      else if (wr && I_PADDR == OFS_REF_STATUS_SAMPLE)
      begin
         st_d.shared_sample_time = wd[POS_SAMPLE_LO +: SAMPLE_W];
      end
      else if (wr && I_PADDR == OFS_TRIGGER_SUSPEND)
      begin
         st_d.reference_select       = wd[POS_REFERENCE_SELECT_LO +: REFERENCE_SELECT_W];
         st_d.suspend                = wd[BIT_SUSPEND];
         st_d.suspend_irq_en         = wd[BIT_SUSP_IRQ_EN];
         st_d.shared_manual_sampling = wd[BIT_MANUAL_SAMP];
         st_d.level_soft_trigger     = wd[BIT_LEVEL_TRIG];
         st_d.trigger_channel_number = wd[POS_CHAN_LO +: CHAN_W];
         st_d.single_channel_trigger = I_PSTRB[1] && I_PWDATA[BIT_CHAN_TRIG];
         st_d.pulse_soft_trigger     = I_PSTRB[0] && I_PWDATA[BIT_PULSE_TRIG];
      end
      // band gap synchroniser
      st_d.bg_meta = I_BANDGAP_READY;
      st_d.bg_sync = st_q.bg_meta;
      st_d.bg_prev = st_q.bg_sync;
      // error held while enabled, set wins over clear
      if (st_q.module_enable && st_q.bg_prev && !st_q.bg_sync)
      begin
         st_d.ref_error_flag = 1'b1;
      end
      else if (!st_q.module_enable)
      begin
         st_d.ref_error_flag = 1'b0;
      end
      st_d.suspended_ready_flag = st_q.suspend && !I_CONV_BUSY;
      st_d.common_irq =
         (st_q.ref_ready_irq_en && st_q.bg_sync && !st_q.bg_prev) ||
         (st_q.ref_error_irq_en && st_d.ref_error_flag
            && !st_q.ref_error_flag) ||
         (st_q.suspend_irq_en && st_d.suspended_ready_flag
            && !st_q.suspended_ready_flag);
   end

   always_ff @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         st_q <= '0;
         st_q.shared_resolution <= RES_RESET;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ************************************************************
   // per-input interrupt source select
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < N_INPUTS; gi++)
      begin : g_irq
         always_ff @(posedge I_MCLK or negedge I_RESETN)
         begin
            if (!I_RESETN)
            begin
               input_irq_q[gi] <= 1'b0;
            end
            else
            begin
               input_irq_q[gi] <= st_q.early_irq_en ? I_EARLY_STATUS[gi]
                                                    : I_CONV_DONE[gi];
            end
         end
      end
   endgenerate

   // ************************************************************
   // outputs to the cores
   // ************************************************************
   assign O_MODULE_ON = st_q.module_enable
                        && !(st_q.idle_stop && I_IDLE);
   assign trig_ok = O_MODULE_ON && !st_q.suspend;
   assign O_FRACTIONAL        = st_q.fractional_format;
   assign O_SHARED_RES        = st_q.shared_resolution;
   assign O_SHARED_RES_BITS   = RES_BASE
                                + {1'b0, st_q.shared_resolution, 1'b0};
   assign O_EARLY_LEAD_CYCLES = {1'b0, st_q.shared_early_lead}
                                + LEAD_ADD;
   assign O_CORE_CLK_DIV      = (st_q.shared_clock_divider == '0) ? DIV_MIN
                                : {st_q.shared_clock_divider, 1'b0};
   assign O_SAMPLE_CYCLES     = {1'b0, st_q.shared_sample_time}
                                + SAMPLE_ADD;
   assign O_REFERENCE_SELECT  = st_q.reference_select;
   assign O_EXT_REQUEST_EN    = st_q.ext_request_en && O_MODULE_ON;
   assign O_MANUAL_SAMPLING   = st_q.shared_manual_sampling;
   assign O_CHANNEL_TRIGGER   = st_q.single_channel_trigger && trig_ok;
   assign O_TRIGGER_CHANNEL   = st_q.trigger_channel_number;
   assign O_LEVEL_TRIGGER     = st_q.level_soft_trigger && trig_ok;
   assign O_PULSE_TRIGGER     = st_q.pulse_soft_trigger && trig_ok;
   assign O_INPUT_IRQ         = input_irq_q;
   assign O_COMMON_IRQ        = st_q.common_irq;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (!I_RESETN);

   a_enable_write: assert property (
      (wr && I_PADDR == OFS_MODULE_CONTROL && I_PSTRB[1])
      |=> st_q.module_enable == $past(I_PWDATA[BIT_MODULE_ENABLE]))
      else $error("module enable not written");
   a_idle_stop_halt: assert property (
      (st_q.idle_stop && I_IDLE) |-> !O_MODULE_ON)
      else $error("module runs in idle with idle stop");
   a_format_write: assert property (
      (wr && I_PADDR == OFS_FORMAT_RESOLUTION && I_PSTRB[0])
      |=> O_FRACTIONAL == $past(I_PWDATA[BIT_FRACTIONAL]))
      else $error("format bit not written");
   a_early_route: assert property (
      $past(st_q.early_irq_en)
      |-> O_INPUT_IRQ == $past(I_EARLY_STATUS))
      else $error("early status not routed");
   a_lead_range: assert property (
      O_EARLY_LEAD_CYCLES >= LEAD_ADD && O_EARLY_LEAD_CYCLES <= 4'h8)
      else $error("early lead out of range");
   a_div_even: assert property (
      O_CORE_CLK_DIV >= DIV_MIN && !O_CORE_CLK_DIV[0])
      else $error("core clock divide invalid");
   a_sample_range: assert property (
      O_SAMPLE_CYCLES >= SAMPLE_ADD && O_SAMPLE_CYCLES <= SAMPLE_MAX)
      else $error("sample time out of range");
   a_ready_irq: assert property (
      ($rose(st_q.bg_sync) && st_q.ref_ready_irq_en) |=> O_COMMON_IRQ)
      else $error("ready interrupt missing");
   a_error_latch: assert property (
      ($fell(st_q.bg_sync) && st_q.module_enable)
      |=> st_q.ref_error_flag [*2])
      else $error("reference error not latched");
   a_suspend_block: assert property (
      st_q.suspend
      |-> !O_CHANNEL_TRIGGER && !O_LEVEL_TRIGGER && !O_PULSE_TRIGGER)
      else $error("trigger passed while suspended");
   a_suspend_ready: assert property (
      (st_q.suspend && !I_CONV_BUSY) |=> st_q.suspended_ready_flag)
      else $error("suspended ready not set");
   a_chan_selfclear: assert property (
      (st_q.single_channel_trigger && !wr) |=> !st_q.single_channel_trigger)
      else $error("channel trigger did not clear");
   a_pulse_selfclear: assert property (
      (st_q.pulse_soft_trigger && !wr) |=> !st_q.pulse_soft_trigger)
      else $error("pulse trigger did not clear");
   a_level_gate: assert property (
      (st_q.level_soft_trigger && trig_ok) |-> O_LEVEL_TRIGGER)
      else $error("level trigger not held");
   a_error_irq: assert property (
      ($rose(st_q.ref_error_flag) && $past(st_q.ref_error_irq_en))
      |-> O_COMMON_IRQ)
      else $error("error interrupt missing");
   a_ready_status: assert property (
      (setup && I_PADDR == OFS_REF_STATUS_SAMPLE)
      |=> O_PRDATA[BIT_REF_READY] == $past(I_BANDGAP_READY, 3))
      else $error("ready status misread");
   a_res_reset: assert property (
      $rose(I_RESETN) |-> O_SHARED_RES_BITS == 4'hC)
      else $error("resolution not twelve after reset");
   a_ext_gate: assert property (
      !O_MODULE_ON |-> !O_EXT_REQUEST_EN)
      else $error("request enabled while off");
   a_error_clear: assert property (
      (!st_q.module_enable && !$past(st_q.module_enable))
      |-> !st_q.ref_error_flag)
      else $error("reference error not cleared");

endmodule
`default_nettype wire

// file: shared/adc_ctl_pkg.sv
package adc_ctl_pkg;

   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [11:0] OFS_MODULE_CONTROL    = 12'h000;
   localparam logic [11:0] OFS_FORMAT_RESOLUTION = 12'h004;
   localparam logic [11:0] OFS_SHARED_TIMING     = 12'h008;
   localparam logic [11:0] OFS_REF_STATUS_SAMPLE = 12'h00C;
   localparam logic [11:0] OFS_TRIGGER_SUSPEND   = 12'h010;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int BIT_MODULE_ENABLE = 15;
   localparam int BIT_IDLE_STOP     = 13;
   localparam int BIT_FRACTIONAL    = 7;
   localparam int POS_RES_LO        = 5;
   localparam int BIT_RDY_IRQ_EN    = 15;
   localparam int BIT_ERR_IRQ_EN    = 14;
   localparam int BIT_EARLY_IRQ_EN  = 12;
   localparam int BIT_EXT_REQ_EN    = 11;
   localparam int POS_LEAD_LO       = 8;
   localparam int POS_DIV_LO        = 0;
   localparam int BIT_REF_READY     = 15;
   localparam int BIT_REF_ERROR     = 14;
   localparam int POS_SAMPLE_LO     = 0;
   localparam int POS_REFERENCE_SELECT_LO     = 13;
   localparam int BIT_SUSPEND       = 12;
   localparam int BIT_SUSP_IRQ_EN   = 11;
   localparam int BIT_SUSP_READY    = 10;
   localparam int BIT_MANUAL_SAMP   = 9;
   localparam int BIT_CHAN_TRIG     = 8;
   localparam int BIT_LEVEL_TRIG    = 7;
   localparam int BIT_PULSE_TRIG    = 6;
   localparam int POS_CHAN_LO       = 0;
   localparam int BYTE_W            = 8;

   // ************************************************************
   // widths, reset values and timing constants
   // ************************************************************
   localparam int RES_W    = 2;
   localparam int LEAD_W   = 3;
   localparam int DIV_W    = 7;
   localparam int SAMPLE_W = 10;
   localparam int REFERENCE_SELECT_W = 3;
   localparam int CHAN_W   = 6;
   localparam logic [RES_W-1:0]    RES_RESET   = 2'h3;
   localparam logic [3:0]          RES_BASE    = 4'h6;
   localparam logic [3:0]          LEAD_ADD    = 4'h1;
   localparam logic [7:0]          DIV_MIN     = 8'h02;
   localparam logic [SAMPLE_W:0]   SAMPLE_ADD  = 11'h002;
   localparam logic [SAMPLE_W:0]   SAMPLE_MAX  = 11'h401;

   typedef struct packed {
      logic                module_enable;
      logic                idle_stop;
      logic                fractional_format;
      logic [RES_W-1:0]    shared_resolution;
      logic                ref_ready_irq_en;
      logic                ref_error_irq_en;
      logic                early_irq_en;
      logic                ext_request_en;
      logic [LEAD_W-1:0]   shared_early_lead;
      logic [DIV_W-1:0]    shared_clock_divider;
      logic [SAMPLE_W-1:0] shared_sample_time;
      logic [REFERENCE_SELECT_W-1:0] reference_select;
      logic                suspend;
      logic                suspend_irq_en;
      logic                suspended_ready_flag;
      logic                shared_manual_sampling;
      logic                single_channel_trigger;
      logic                level_soft_trigger;
      logic                pulse_soft_trigger;
      logic [CHAN_W-1:0]   trigger_channel_number;
      logic                bg_meta;
      logic                bg_sync;
      logic                bg_prev;
      logic                ref_error_flag;
      logic                common_irq;
      logic [31:0]         prdata;
   } state_t;

endpackage

// file: testbench/adc_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module adc_core_model
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // trigger side
   input  wire logic        i_trigger,
   input  wire logic [5:0]  i_channel,
   input  wire logic [3:0]  i_lead,
   input  wire logic        i_slow,
   // status toward the control block
   output var  logic        o_busy = 1'b0,
   output var  logic [23:0] o_early = 24'h000000,
   output var  logic [23:0] o_done = 24'h000000
);
   int         left;
   logic [5:0] chan;
   // ************************************************************
   // one conversion at a time, prompt or slow
   // ************************************************************
   always @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         left    <= 0;
         chan    <= 6'h00;
         o_busy  <= 1'b0;
         o_early <= 24'h000000;
         o_done  <= 24'h000000;
      end
      else
      begin
         o_early <= (left == int'(i_lead) + 1) ? 24'h000001 << chan
                                                : 24'h000000;
         o_done  <= (left == 1) ? 24'h000001 << chan : 24'h000000;
         o_busy  <= left > 1 || (i_trigger && left == 0);
         if (left > 0)
            left <= left - 1;
         else if (i_trigger)
         begin
            left <= i_slow ? 40 : 12;
            chan <= i_channel;
         end
      end
   end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import adc_ctl_pkg::*;
   // ************************************************************
   // signals and bench state
   // ************************************************************
   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0]  pstrb = 4'hF;
   logic        idle = 1'b0;
   logic        bg = 1'b0;
   logic        slow = 1'b0;
   logic        early_en_q = 1'b0;
   logic [31:0] prdata, rdv;
   logic [31:0] rnd_s = 32'h00000060;
   logic        pready, pslverr, module_on, fractional, ext_en, man_samp;
   logic        chan_trig, lvl_trig, pls_trig, com_irq, busy, err;
   logic [1:0]  res;
   logic [3:0]  res_bits, lead_cyc;
   logic [7:0]  clk_div;
   logic [10:0] samp_cyc;
   logic [2:0]  ref_sel;
   logic [5:0]  trig_chan;
   logic [23:0] in_irq, early, done, exp_irq;
   logic [15:0] w;
   logic [15:0] shad[5];
   logic [15:0] fix_w[9] = '{16'h0000, 16'h0020, 16'h0040, 16'h00E0,
                             16'h0000, 16'h0001, 16'h077F, 16'h0000, 16'h03FF};
   logic [15:0] rw_mask[5] = '{16'hA000, 16'h00E0, 16'hDF7F, 16'h03FF,
                               16'hFABF};
   int          fix_idx[9] = '{1, 1, 1, 1, 2, 2, 2, 3, 3};
   int          err_total = 0;
   int          n_tests = 0;
   int          irq_cnt = 0;
   int          chan_cnt = 0;
   int          pls_cnt = 0;
   int          idx, base, n;

   always #12.5 mclk = ~mclk;

   adc_common_ctl #(.N_INPUTS(24)) adc_common_ctl_inst (
      .I_MCLK(mclk), .I_RESETN(resetn), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .I_IDLE(idle), .I_BANDGAP_READY(bg), .I_CONV_BUSY(busy),
      .I_EARLY_STATUS(early), .I_CONV_DONE(done), .O_MODULE_ON(module_on),
      .O_FRACTIONAL(fractional), .O_SHARED_RES(res),
      .O_SHARED_RES_BITS(res_bits), .O_EARLY_LEAD_CYCLES(lead_cyc),
      .O_CORE_CLK_DIV(clk_div), .O_SAMPLE_CYCLES(samp_cyc),
      .O_REFERENCE_SELECT(ref_sel), .O_EXT_REQUEST_EN(ext_en),
      .O_MANUAL_SAMPLING(man_samp), .O_CHANNEL_TRIGGER(chan_trig),
      .O_TRIGGER_CHANNEL(trig_chan), .O_LEVEL_TRIGGER(lvl_trig),
      .O_PULSE_TRIGGER(pls_trig), .O_INPUT_IRQ(in_irq), .O_COMMON_IRQ(com_irq));

   adc_core_model adc_core_model_inst (
      .i_clk(mclk), .i_resetn(resetn), .i_trigger(chan_trig | pls_trig),
      .i_channel(chan_trig ? trig_chan : 6'h00), .i_lead(lead_cyc),
      .i_slow(slow), .o_busy(busy), .o_early(early), .o_done(done));

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want)
      begin
         err_total++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask

   task automatic end_of_test();
      if (err_total == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic apb(input logic wr, input int a, input logic [15:0] wd,
                      input logic [3:0] st = 4'hF);
      @(posedge mclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a[11:0];
      pwdata  <= {16'h0000, wd};
      pstrb   <= st;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
      begin
         @(posedge mclk);
      end
      rdv = prdata;
      err = pslverr;
      if (wr && a == 8 && st[1])
         early_en_q <= wd[BIT_EARLY_IRQ_EN];
      psel    <= 1'b0;
      penable <= 1'b0;
      @(negedge mclk);
   endtask

   // ************************************************************
   // reference model of per-input interrupts and event counters
   // ************************************************************
   always @(posedge mclk or negedge resetn)
      if (!resetn)
         exp_irq <= 24'h000000;
      else
         exp_irq <= early_en_q ? early : done;

   always @(negedge mclk)
   begin
      if (resetn)
      begin
         chk(in_irq, exp_irq);
         irq_cnt  <= irq_cnt + int'(com_irq === 1'b1);
         chan_cnt <= chan_cnt + int'(chan_trig === 1'b1);
         pls_cnt  <= pls_cnt + int'(pls_trig === 1'b1);
      end
   end

   initial
   begin
      #1000000;
      err_total++;
      end_of_test();
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         apb(0, i * 4, 16'h0000);
         chk(rdv, (i == 1) ? 32'h00000060 : 32'h00000000);
      end
      apb(0, 20, 16'h0000);
      chk(err, 1'b1);
      chk(rdv, 32'h00000000);
      for (int i = 0; i < 39; i++)
      begin
         if (i < 9)
         begin
            idx = fix_idx[i];
            w   = fix_w[i];
         end
         else
         begin
            rnd_s = xorshift(rnd_s);
            idx   = int'(rnd_s[2:0]) % 5;
            w     = rnd_s[31:16];
         end
         if (idx == 0)
            w = w & 16'h77FF;
         if (idx == 3)
            w = w & 16'hE3FF;
         if (idx == 2 && shad[1][6:5] != 2'b11)
            w = w & 16'hFBFF;
         if (idx == 1 && shad[2][10])
            w = w | 16'h0060;
         shad[idx] = w;
         apb(1, idx * 4, w);
         if (idx == 1)
         begin
            chk(res_bits, 6 + 2 * w[6:5]);
            chk(res, w[6:5]);
            chk(fractional, w[7]);
         end
         if (idx == 2)
         begin
            chk(lead_cyc, w[10:8] + 1);
            chk(clk_div, (w[6:0] == 7'h00) ? 2 : 2 * w[6:0]);
            chk(ext_en, 1'b0);
         end
         if (idx == 3)
            chk(samp_cyc, w[9:0] + 2);
         if (idx == 4)
         begin
            chk(ref_sel, w[15:13]);
            chk({man_samp, trig_chan}, {w[9], w[5:0]});
         end
         apb(0, idx * 4, 16'h0000);
         chk(rdv, (w & rw_mask[idx])
            | ((idx == 4 && w[12]) ? 16'h0400 : 16'h0000));
      end
      apb(1, 4, 16'h0000, 4'h2);
      apb(0, 4, 16'h0000);
      chk(rdv, shad[1] & 16'h00E0);
      apb(1, 16, 16'h0000);
      apb(1, 8, 16'hC800);
      base = irq_cnt;
      apb(1, 0, 16'h8000);
      chk({module_on, ext_en}, 2'b11);
      apb(1, 0, 16'hA000);
      @(posedge mclk);
      idle <= 1'b1;
      @(negedge mclk);
      chk({module_on, ext_en}, 2'b00);
      @(posedge mclk);
      idle <= 1'b0;
      bg <= 1'b1;
      repeat (5) @(negedge mclk);
      chk(irq_cnt - base, 1);
      apb(0, 12, 16'h0000);
      chk(rdv[15:14], 2'b10);
      @(posedge mclk);
      bg <= 1'b0;
      repeat (5) @(negedge mclk);
      chk(irq_cnt - base, 2);
      apb(0, 12, 16'h0000);
      chk(rdv[15:14], 2'b01);
      apb(1, 0, 16'h0000);
      apb(0, 12, 16'h0000);
      chk(rdv[14], 1'b0);
      apb(1, 0, 16'h8000);
      apb(1, 16, 16'h0105);
      repeat (3) @(negedge mclk);
      chk(chan_cnt, 1);
      chk(trig_chan, 6'h05);
      repeat (20) @(negedge mclk);
      apb(0, 16, 16'h0000);
      chk(rdv[8], 1'b0);
      apb(1, 16, 16'h0040);
      repeat (23) @(negedge mclk);
      chk(pls_cnt, 1);
      apb(1, 16, 16'h0080);
      chk(lvl_trig, 1'b1);
      apb(1, 16, 16'h11C0);
      repeat (3) @(negedge mclk);
      chk(chan_cnt, 1);
      chk(pls_cnt, 1);
      chk(lvl_trig, 1'b0);
      apb(1, 16, 16'h0000);
      slow <= 1'b1;
      apb(1, 16, 16'h0105);
      apb(1, 16, 16'h1800);
      apb(0, 16, 16'h0000);
      chk(rdv[10], 1'b0);
      n = 0;
      while (busy !== 1'b0 && n < 100)
      begin
         @(negedge mclk);
         n++;
      end
      chk(busy, 1'b0);
      repeat (3) @(negedge mclk);
      apb(0, 16, 16'h0000);
      chk(rdv[10], 1'b1);
      chk(irq_cnt - base, 3);
      apb(1, 16, 16'h0000);
      apb(1, 0, 16'h0000);
      apb(1, 8, 16'h1800);
      apb(1, 0, 16'h8000);
      slow <= 1'b0;
      apb(1, 16, 16'h0103);
      repeat (20) @(negedge mclk);
      chk(chan_cnt, 3);
      end_of_test();
   end
endmodule
`default_nettype wire
